// [src/numeric_oscillator.sv]
// numeric oscillator: accumulator, fixed duty and pulse output stage,
// polarity, overflow interrupt and register port
// assumes clk is the selected source clock and bus strobes are one cycle
//
// Summary of operation
// R1: add increment each source cycle, carry is overflow
// R2: fixed duty mode toggles output per overflow
// R3: mode select zero picks fixed duty
// R4: pulse mode: active pulse, then inactive
// R5: pulse starts on edge after overflow
// R6: mode select one picks pulse mode
// R7: three-bit select sets pulse width
// R8: width beyond overflow interval holds output
// R9: polarity select applied as last stage
// R10: polarity change with interrupt enabled flags event
// R11: every overflow sets the overflow flag
// R12: interrupt needs all four enables set
// R13: software clears the flag, never hardware
// R14: reset clears every register to zero
// R15: runs from own source, also in sleep
// R16: keep internal oscillator alive in sleep
// R17: output routed to five on-chip consumers
`timescale 1ns/1ps
module numeric_oscillator
   import numeric_oscillator_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic sleep,
   output logic [DATA_W-1:0] rdata_r,
   output logic oscillator_output_r,
   output logic [ROUTE_N-1:0] osc_route_r,
   output logic hfint_keep_r,
   output logic irq_r
);
   // register state of the block, apart from the flag and the pulse timer
   typedef struct packed
   {
      logic en;                                        // module_enable_bit
      logic pfm;                                       // pulse_mode_select
      logic pol;                                       // output_polarity_select
      logic [2:0] pws;                                 // pulse_width_select
      logic [1:0] clksel;                              // clock source select
      logic [ACC_W-1:0] inc;                           // increment value
      logic [ACC_W-1:0] acc;                           // accumulator
      logic ie;                                        // overflow_irq_enable
      logic peripheral_irq_enable;                                      // peripheral_irq_enable
      logic global_irq_enable;                                       // global_irq_enable
      logic level;                                     // fixed duty toggle level
      logic out;                                       // final oscillator_output
      logic [ROUTE_N-1:0] route;                       // copies for the consumers
      logic keep;                                      // hold the internal oscillator
      logic [DATA_W-1:0] rdata;                        // read data, one cycle late
   } osc_state_t;

   osc_state_t st_r;
   osc_state_t st_nxt;

   logic [ACC_W:0] sum;                                // accumulator plus carry
   logic ovf_now;                                      // accumulator_overflow this cycle
   logic pulse_start;                                  // launch a pulse mode pulse
   logic pulse_clear;                                  // hold the pulse timer idle
   logic pulse_active_nxt;                             // timer level after this edge
   logic raw_nxt;                                      // output before polarity
   logic pol_evt;                                      // polarity driven transition
   logic flag_set;                                     // any flag raising event
   logic flag_clr;                                     // software write-one-to-clear
   logic gate_all;                                     // all four enables
   logic flag_r;                                       // overflow_irq_flag

   // address match, used by both the write and the read decode
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
      hit = (a == ofs);
   endfunction

   // accumulator addition, widened by one bit to keep the carry
   assign sum = {1'b0, st_r.acc} + {1'b0, st_r.inc};   // R1
   // no overflow is counted while the module is off
   assign ovf_now = st_r.en & sum[ACC_W];               // R1

   // pulse timer is only used in pulse mode; fixed duty keeps it idle
   assign pulse_start = ovf_now & st_r.pfm;             // R6
   assign pulse_clear = ~st_r.en | ~st_r.pfm;

   // software clears the flag by writing a one to its bit
   assign flag_clr = wr_en & hit(addr, OFS_REQ) & wdata[REQ_FLAG_POS];

   // the interrupt is forwarded only with every enable set
   assign gate_all = st_r.en & st_r.ie & st_r.peripheral_irq_enable & st_r.global_irq_enable; // R12

   pulse_width_timer u_pulse
   (
      .clk(clk),
      .rst(rst),
      .start(pulse_start),
      .clear(pulse_clear),
      .width_sel(st_r.pws),
      .active_nxt(pulse_active_nxt)
   );

   overflow_irq_cell u_irq
   (
      .clk(clk),
      .rst(rst),
      .set_evt(flag_set),
      .clr_req(flag_clr),
      .gate_all(gate_all),
      .flag_r(flag_r),
      .irq_r(irq_r)
   );

   // next state: register writes, accumulator, output stage and read data
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.rdata = RST_ZERO;
      raw_nxt = 1'b0;
      // register writes; the flag lives in the interrupt cell
      if (wr_en)
      begin
         if (hit(addr, OFS_CTRL))
         begin
            st_nxt.en = wdata[CTRL_EN_POS];
            st_nxt.pfm = wdata[CTRL_PFM_POS];
            st_nxt.pol = wdata[CTRL_POL_POS];
         end
         else if (hit(addr, OFS_CLK))
         begin
            st_nxt.pws = wdata[CLK_PWS_POS +: 3];
            st_nxt.clksel = wdata[CLK_SEL_POS +: 2];
         end
         else if (hit(addr, OFS_INC))
         begin
            st_nxt.inc = wdata[ACC_W-1:0];
         end
         else if (hit(addr, OFS_IEN))
         begin
            st_nxt.ie = wdata[IEN_IE_POS];
         end
         else if (hit(addr, OFS_ICON))
         begin
            st_nxt.peripheral_irq_enable = wdata[ICON_PERIPHERAL_IRQ_ENABLE_POS];
            st_nxt.global_irq_enable = wdata[ICON_GIE_POS];
         end
         else
         begin
            // unmapped or read-only offsets ignore writes
            st_nxt.en = st_r.en;
         end
      end
      // accumulator runs on every source edge while enabled, sleep or not
      if (st_r.en)
      begin
         st_nxt.acc = sum[ACC_W-1:0];                  // R1 R15
      end
      // fixed duty toggle; cleared when off or in pulse mode
      if (!st_r.en || st_r.pfm)
      begin
         st_nxt.level = 1'b0;
      end
      else if (ovf_now)
      begin
         st_nxt.level = ~st_r.level;                   // R2 R3
      end
      // choose the active level source by mode
      if (!st_r.en)
      begin
         raw_nxt = 1'b0;                               // off shows the inactive level
      end
      else if (st_r.pfm)
      begin
         raw_nxt = pulse_active_nxt;                   // R4 R6
      end
      else
      begin
         raw_nxt = st_nxt.level;                       // R3
      end
      // polarity is the very last stage, taken from the new setting so
      // that a polarity write shows on the next edge
      st_nxt.out = raw_nxt ^ st_nxt.pol;               // R9
      st_nxt.route = {ROUTE_N{st_nxt.out}};            // R17
      // keep the internal oscillator alive while asleep and in use
      st_nxt.keep = st_nxt.en & sleep & (st_nxt.clksel == SRC_HFINT); // R16
      // read data, presented in the cycle after the strobe only
      if (rd_en)
      begin
         if (hit(addr, OFS_CTRL))
         begin
            st_nxt.rdata[CTRL_EN_POS] = st_r.en;
            st_nxt.rdata[CTRL_PFM_POS] = st_r.pfm;
            st_nxt.rdata[CTRL_POL_POS] = st_r.pol;
            st_nxt.rdata[CTRL_OUT_POS] = st_r.out;
         end
         else if (hit(addr, OFS_CLK))
         begin
            st_nxt.rdata[CLK_PWS_POS +: 3] = st_r.pws;
            st_nxt.rdata[CLK_SEL_POS +: 2] = st_r.clksel;
         end
         else if (hit(addr, OFS_INC))
         begin
            st_nxt.rdata[ACC_W-1:0] = st_r.inc;
         end
         else if (hit(addr, OFS_ACC))
         begin
            st_nxt.rdata[ACC_W-1:0] = st_r.acc;
         end
         else if (hit(addr, OFS_REQ))
         begin
            st_nxt.rdata[REQ_FLAG_POS] = flag_r;
         end
         else if (hit(addr, OFS_IEN))
         begin
            st_nxt.rdata[IEN_IE_POS] = st_r.ie;
         end
         else if (hit(addr, OFS_ICON))
         begin
            st_nxt.rdata[ICON_PERIPHERAL_IRQ_ENABLE_POS] = st_r.peripheral_irq_enable;
            st_nxt.rdata[ICON_GIE_POS] = st_r.global_irq_enable;
         end
         else
         begin
            // unmapped offsets read as zero
            st_nxt.rdata = RST_ZERO;
         end
      end
   end

   // a polarity write that flips the output counts as an event, but only
   // while the overflow interrupt is enabled; otherwise it stays silent
   assign pol_evt = (st_nxt.pol != st_r.pol) & (st_nxt.out != st_r.out) & st_r.ie; // R10
   assign flag_set = ovf_now | pol_evt;                // R11 R10

   // state register; reset clears everything to zero
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         st_r <= '0;                                   // R14
      else
         st_r <= st_nxt;
   end

   // outputs come straight from the state register
   assign rdata_r = st_r.rdata;
   assign oscillator_output_r = st_r.out;
   assign osc_route_r = st_r.route;
   assign hfint_keep_r = st_r.keep;

   // checks kept beside the logic they guard
   a_ovf_sets_flag: assert property (@(posedge clk) disable iff (rst) // R11
      ovf_now |=> flag_r)
      else $error("overflow did not set the flag");

   a_fixed_toggles: assert property (@(posedge clk) disable iff (rst) // R2
      ovf_now && !st_r.pfm && !wr_en |=> st_r.out != $past(st_r.out))
      else $error("fixed duty output did not toggle");

   a_fixed_holds: assert property (@(posedge clk) disable iff (rst) // R3
      st_r.en && !st_r.pfm && !ovf_now && !wr_en |=> st_r.out == $past(st_r.out))
      else $error("fixed duty output moved without overflow");

   a_pulse_active: assert property (@(posedge clk) disable iff (rst) // R5
      ovf_now && st_r.pfm && !wr_en |=> st_r.out == !st_r.pol)
      else $error("pulse not active after overflow");

   a_pulse_returns: assert property (@(posedge clk) disable iff (rst) // R4
      ovf_now && st_r.pfm && st_r.pws == 3'h1 && !wr_en
      ##1 !ovf_now && !wr_en ##1 !ovf_now && !wr_en |=> st_r.out == st_r.pol)
      else $error("two period pulse did not end");

   a_off_inactive: assert property (@(posedge clk) disable iff (rst) // R9
      !st_r.en && !wr_en |=> st_r.out == st_r.pol)
      else $error("disabled output not at inactive level");

   a_pol_event: assert property (@(posedge clk) disable iff (rst) // R10
      pol_evt |=> flag_r && st_r.out != $past(st_r.out))
      else $error("polarity transition not flagged");

   a_keep_hfint: assert property (@(posedge clk) disable iff (rst) // R16
      st_r.en && sleep && st_r.clksel == SRC_HFINT && !wr_en |=> hfint_keep_r)
      else $error("internal oscillator dropped in sleep");

   a_runs_in_sleep: assert property (@(posedge clk) disable iff (rst) // R15
      st_r.en && sleep |=> st_r.acc == $past(sum[ACC_W-1:0]))
      else $error("accumulator stalled");

   a_route_follows: assert property (@(posedge clk) disable iff (rst) // R17
      osc_route_r[ROUTE_REFERENCE_CLOCK_OUTPUT] == oscillator_output_r && osc_route_r[ROUTE_CLC] == st_r.out)
      else $error("consumer copy differs from output");
endmodule // numeric_oscillator

// [include/numeric_oscillator_pkg.sv]
// constants shared by the numeric oscillator output stage and its helpers
// assumes a single 50 MHz clock that is also the selected source clock
package numeric_oscillator_pkg;
   localparam int ADDR_W = 8;                          // register address width
   localparam int DATA_W = 32;                         // register data width
   localparam int ACC_W = 20;                          // accumulator and increment width
   localparam int PCNT_W = 8;                          // pulse width counter width
   localparam int ROUTE_N = 5;                         // number of on-chip consumers
   // byte offsets of the registers
   localparam logic [7:0] OFS_CTRL = 8'h00;            // oscillator_control_reg
   localparam logic [7:0] OFS_CLK = 8'h04;             // oscillator_clock_reg
   localparam logic [7:0] OFS_INC = 8'h08;             // increment value
   localparam logic [7:0] OFS_ACC = 8'h0C;             // accumulator, read only
   localparam logic [7:0] OFS_REQ = 8'h10;             // peripheral_request_reg
   localparam logic [7:0] OFS_IEN = 8'h14;             // peripheral_enable_reg
   localparam logic [7:0] OFS_ICON = 8'h18;            // interrupt_control_reg
   // field positions
   localparam int CTRL_EN_POS = 0;                     // module_enable_bit
   localparam int CTRL_PFM_POS = 1;                    // pulse_mode_select
   localparam int CTRL_POL_POS = 2;                    // output_polarity_select
   localparam int CTRL_OUT_POS = 3;                    // output level, read only
   localparam int CLK_PWS_POS = 0;                     // pulse_width_select, 3 bits
   localparam int CLK_SEL_POS = 4;                     // clock source select, 2 bits
   localparam int REQ_FLAG_POS = 0;                    // overflow_irq_flag
   localparam int IEN_IE_POS = 0;                      // overflow_irq_enable
   localparam int ICON_PERIPHERAL_IRQ_ENABLE_POS = 0;                   // peripheral_irq_enable
   localparam int ICON_GIE_POS = 1;                    // global_irq_enable
   // consumer positions in the route vector
   localparam int ROUTE_CLC = 0;                       // configurable_logic_cell
   localparam int ROUTE_CWG = 1;                       // complementary_waveform_gen
   localparam int ROUTE_TMR_A = 2;                     // first timer
   localparam int ROUTE_TMR_B = 3;                     // second timer
   localparam int ROUTE_REFERENCE_CLOCK_OUTPUT = 4;                      // reference_clock_output
   // source select code of the high_freq_internal_osc
   localparam logic [1:0] SRC_HFINT = 2'h1;
   // every register clears to this after reset
   localparam logic [DATA_W-1:0] RST_ZERO = 32'h0000_0000;
   // pulse width is one source period shifted left by the select value
   localparam logic [PCNT_W-1:0] PULSE_UNIT = 8'h01;
endpackage

// [src/pulse_width_timer.sv]
// pulse width timer for the pulse frequency mode of the numeric oscillator
// assumes start and clear come from the owner's own clock domain
`timescale 1ns/1ps
module pulse_width_timer
   import numeric_oscillator_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic start,
   input wire logic clear,
   input wire logic [2:0] width_sel,
   output logic active_nxt
);
   typedef struct packed
   {
      logic active;                                    // pulse is in its active level
      logic [PCNT_W-1:0] cnt;                          // periods still to run after this
   } timer_state_t;

   timer_state_t st_r;
   timer_state_t st_nxt;

   // next state: a new start restarts the count, so a width longer than
   // the overflow interval just keeps the output active
   always_comb
   begin
      st_nxt = st_r;
      if (clear)
      begin
         st_nxt = '0;
      end
      else if (start)
      begin
         st_nxt.active = 1'b1;                                    // R5
         st_nxt.cnt = (PULSE_UNIT << width_sel) - PULSE_UNIT;     // R7 R8
      end
      else if (st_r.cnt != '0)
      begin
         st_nxt.active = 1'b1;                                    // R4
         st_nxt.cnt = st_r.cnt - PULSE_UNIT;
      end
      else
      begin
         st_nxt.active = 1'b0;                                    // R4
      end
   end

   assign active_nxt = st_nxt.active;

   // state register
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   a_start_goes_active: assert property (@(posedge clk) disable iff (rst) // R5
      start && !clear |=> st_r.active)
      else $error("pulse not active after start");

   a_min_width_ends: assert property (@(posedge clk) disable iff (rst) // R7
      start && !clear && width_sel == 3'h0 ##1 !start && !clear |=> !st_r.active)
      else $error("one period pulse did not end");
endmodule // pulse_width_timer

// [src/overflow_irq_cell.sv]
// sticky overflow flag with write-one-to-clear and gated interrupt output
// assumes the four enables are already combined by the owner
`timescale 1ns/1ps
module overflow_irq_cell
   import numeric_oscillator_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic set_evt,
   input wire logic clr_req,
   input wire logic gate_all,
   output logic flag_r,
   output logic irq_r
);
   typedef struct packed
   {
      logic flag;                                      // overflow_irq_flag
      logic irq;                                       // registered interrupt level
   } irq_state_t;

   irq_state_t st_r;
   irq_state_t st_nxt;

   // set wins over a clear in the same cycle so no event is lost;
   // hardware never clears the flag by itself
   always_comb
   begin
      st_nxt = st_r;
      if (set_evt)
         st_nxt.flag = 1'b1;                           // R11
      else if (clr_req)
         st_nxt.flag = 1'b0;                           // R13
      st_nxt.irq = st_nxt.flag & gate_all;             // R12
   end

   assign flag_r = st_r.flag;
   assign irq_r = st_r.irq;

   // state register
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   a_flag_no_autoclr: assert property (@(posedge clk) disable iff (rst) // R13
      st_r.flag && !clr_req |=> st_r.flag)
      else $error("flag cleared without software");

   a_set_beats_clr: assert property (@(posedge clk) disable iff (rst) // R11
      set_evt |=> st_r.flag)
      else $error("flag event lost");

   a_irq_gated: assert property (@(posedge clk) disable iff (rst) // R12
      st_r.irq |-> $past(gate_all) && st_r.flag)
      else $error("interrupt without all enables");
endmodule // overflow_irq_cell

// [verif/route_consumer.sv]
// model of the on-chip consumers of the oscillator output, one edge counter per copy
// assumes the copies are registered in the clk domain and cleared by rst
`timescale 1ns/1ps
module route_consumer
   import numeric_oscillator_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [ROUTE_N-1:0] route,
   output logic [ROUTE_N-1:0][15:0] rise_cnt
);
   logic [ROUTE_N-1:0] prev_r; // last level seen on each copy
   // counting per copy shows a copy that is missing or stuck, not only a late one
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         prev_r <= '0;
         rise_cnt <= '0;
      end
      else
      begin
         prev_r <= route;
         for (int i = 0; i < ROUTE_N; i++)
         begin
            if (route[i] && !prev_r[i])
               rise_cnt[i] <= rise_cnt[i] + 16'h0001;
         end
      end
   end
endmodule // route_consumer

// [verif/test_accumulator_frequency_output.sv]
// self-checking bench of the numeric oscillator: bus tasks, cycle model, consumer model
// assumes one 50 MHz clock that is also the oscillator source
`timescale 1ns/1ps
module test_accumulator_frequency_output
   import numeric_oscillator_pkg::*;
;
   logic clk, rst, wr_en, rd_en, sleep, chk_on; // bench drives and check gate
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata, rdata_r, d;
   logic oscillator_output_r, hfint_keep_r, irq_r;
   logic [ROUTE_N-1:0] osc_route_r;
   logic [ROUTE_N-1:0][15:0] rise_cnt; // edges seen by each consumer
   int mismatches, samples_checked;
   integer seed;
   logic [31:0] rnd;
   // reference model state
   logic [ACC_W-1:0] acc_m, inc_m;
   logic [ACC_W:0] sum_m;
   logic en_m, pfm_m, pol_m, r_m, nr, pn, out_m, prev_m, ovf_m;
   logic [2:0] pws_m;
   logic [7:0] cnt_m;
   logic [15:0] rise_m;
   logic [7:0] rst_addrs [8];

   numeric_oscillator u_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
      .wr_en(wr_en), .rd_en(rd_en), .sleep(sleep), .rdata_r(rdata_r),
      .oscillator_output_r(oscillator_output_r), .osc_route_r(osc_route_r),
      .hfint_keep_r(hfint_keep_r), .irq_r(irq_r));
   route_consumer u_consumer (.clk(clk), .rst(rst), .route(osc_route_r), .rise_cnt(rise_cnt));

   initial clk = 1'b0;
   always #10 clk = ~clk;

   // cycle model: snoops the same bus writes the design takes
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         {acc_m, inc_m, en_m, pfm_m, pol_m, r_m, out_m, prev_m, ovf_m, pws_m, cnt_m} <= '0;
         rise_m <= 16'h0000;
      end
      else
      begin
         sum_m = {1'b0, acc_m} + {1'b0, inc_m};
         nr = r_m;
         if (!en_m)
            nr = 1'b0;
         else if (sum_m[ACC_W])
         begin
            nr = pfm_m ? 1'b1 : !r_m;
            cnt_m <= (8'h01 << pws_m) - 8'h01;
         end
         else if (pfm_m && cnt_m != 8'h00)
            cnt_m <= cnt_m - 8'h01;
         else if (pfm_m)
            nr = 1'b0;
         if (en_m)
            acc_m <= sum_m[ACC_W-1:0];
         ovf_m <= ovf_m | (en_m & sum_m[ACC_W]);
         r_m <= nr;
         // polarity is the last stage; a polarity write reaches the output on its own edge
         pn = (wr_en && addr == OFS_CTRL) ? wdata[CTRL_POL_POS] : pol_m;
         out_m <= nr ^ pn;
         prev_m <= out_m;
         if (out_m && !prev_m)
            rise_m <= rise_m + 16'h0001;
         if (wr_en && addr == OFS_CTRL)
            {pol_m, pfm_m, en_m} <= wdata[2:0];
         if (wr_en && addr == OFS_INC)
            inc_m <= wdata[ACC_W-1:0];
         if (wr_en && addr == OFS_CLK)
            pws_m <= wdata[2:0];
      end
   end

   task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp,
      input string what);
      samples_checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // output compared every cycle of each run while chk_on is set, on the falling edge where it has settled
   always @(negedge clk)
   begin
      if (chk_on && !rst)
         check(oscillator_output_r, out_m, "output level");
   end

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [DATA_W-1:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [DATA_W-1:0] v);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 v = rdata_r;
   endtask

   task automatic restart();
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
   endtask

   // one configured run, then the consumers and the flag are compared with the model
   task automatic run_case(input logic [ACC_W-1:0] inc, input logic pfm, input logic pol,
      input logic [2:0] pws, input int ncyc);
      restart();
      chk_on <= 1'b1;
      wr(OFS_INC, {12'h000, inc});
      wr(OFS_CLK, {29'h0, pws});
      wr(OFS_CTRL, {29'h0, pol, pfm, 1'b0});
      wr(OFS_CTRL, {29'h0, pol, pfm, 1'b1});
      repeat (ncyc)
      begin
         @(posedge clk);
         rnd = $random(seed);
         sleep <= rnd[0];
      end
      wr(OFS_CTRL, {29'h0, pol, pfm, 1'b0});
      repeat (4) @(posedge clk);
      chk_on <= 1'b0;
      for (int i = 0; i < ROUTE_N; i++)
         check(rise_cnt[i], rise_m, "consumer edges");
      rd(OFS_ACC, d);
      check(d, {12'h000, acc_m}, "accumulator");
      rd(OFS_REQ, d);
      check(d, {31'h0, ovf_m}, "overflow flag");
      $display("run done inc %h mode %0d width %0d", inc, pfm, pws);
   endtask

   initial
   begin
      {wr_en, rd_en, sleep, chk_on, addr, wdata} = '0;
      rst = 1'b1;
      seed = 32'h5341;
      mismatches = 0;
      samples_checked = 0;
      rst_addrs = '{OFS_CTRL, OFS_CLK, OFS_INC, OFS_ACC, OFS_REQ, OFS_IEN, OFS_ICON, 8'h40};
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      foreach (rst_addrs[i])
      begin
         rd(rst_addrs[i], d);
         check(d, RST_ZERO, "reset value");
      end
      rnd = $random(seed);
      wr(OFS_INC, rnd);
      wr(OFS_ACC, 32'hFFFF_FFFF);
      rd(OFS_INC, d);
      check(d, {12'h000, rnd[ACC_W-1:0]}, "increment readback");
      rd(OFS_ACC, d);
      check(d, RST_ZERO, "accumulator read only");
      $display("register test done");
      run_case(20'hFFFFF, 1'b0, 1'b0, 3'h0, 60);
      run_case(20'h40000, 1'b1, 1'b1, 3'h3, 60);
      run_case(20'h80000, 1'b1, 1'b0, 3'h0, 40);
      for (int p = 0; p < 8; p++)
      begin
         rnd = $random(seed);
         run_case(rnd[ACC_W-1:0], 1'b1, rnd[31], p[2:0], 150);
      end
      for (int k = 0; k < 4; k++)
      begin
         rnd = $random(seed);
         run_case(rnd[ACC_W-1:0], 1'b0, rnd[31], rnd[22:20], 200);
      end
      // interrupt gating over every combination of the four enables
      restart();
      wr(OFS_INC, 32'h000F_FFFF);
      wr(OFS_CTRL, 32'h0000_0001);
      repeat (4) @(posedge clk);
      for (int i = 0; i < 16; i++)
      begin
         wr(OFS_CTRL, {31'h0, i[0]});
         wr(OFS_IEN, {31'h0, i[1]});
         wr(OFS_ICON, {30'h0, i[3:2]});
         repeat (3) @(posedge clk);
         check(irq_r, &i[3:0], "interrupt gate");
      end
      repeat (50) @(posedge clk);
      rd(OFS_REQ, d);
      check(d, 32'h0000_0001, "flag stays set");
      // stop the overflows first, or the next one sets the flag again at once
      wr(OFS_INC, RST_ZERO);
      wr(OFS_REQ, 32'h0000_0001);
      repeat (2) @(posedge clk);
      rd(OFS_REQ, d);
      check(d, RST_ZERO, "flag cleared by software");
      check(irq_r, 1'b0, "interrupt dropped");
      wr(OFS_CTRL, 32'h0000_0005);
      repeat (3) @(posedge clk);
      rd(OFS_REQ, d);
      check(d, 32'h0000_0001, "polarity change event");
      $display("interrupt test done");
      // oscillator keep-alive over sleep and every source code
      restart();
      wr(OFS_CTRL, 32'h0000_0001);
      for (int i = 0; i < 8; i++)
      begin
         sleep <= i[0];
         wr(OFS_CLK, {26'h0, i[2:1], 4'h0});
         repeat (3) @(posedge clk);
         check(hfint_keep_r, i[0] && (i[2:1] == SRC_HFINT), "keep alive");
      end
      $display("sleep test done");
      conclude();
   end

   // cuts a hang short
   initial
   begin
      repeat (100000) @(posedge clk);
      mismatches++;
      $display("CHECK FAILED at %0t: run did not finish", $time);
      conclude();
   end
endmodule // test_accumulator_frequency_output
